// *** flash_erase_params.svh ***
// Purpose: constants of the erase / suspend / resume command logic
// Assumes: 125 MHz core clock; times are whole units
// Notes: opcodes, address field positions and timing figures
`ifndef FLASH_ERASE_PARAMS_SVH
`define FLASH_ERASE_PARAMS_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_SECTOR_ERASE 8'h20
`define OP_BLK32_ERASE 8'h52
`define OP_BLK64_ERASE 8'hD8
`define OP_CHIP_ERASE_A 8'hC7
`define OP_CHIP_ERASE_B 8'h60
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7A

// ----------------------------------------
// frame lengths in bytes and address fields
// ----------------------------------------
`define LEN_ADDR_CMD 3'h4
`define LEN_BARE_CMD 3'h1
`define SECTOR_ADDR_LSB 12
`define BLK32_ADDR_LSB 15
`define BLK64_ADDR_LSB 16

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 125
`define SECTOR_ERASE_US 400
`define BLK32_ERASE_US 1600
`define BLK64_ERASE_US 2000
`define CHIP_ERASE_US 40000
`define SUSPEND_LAT_US 5
`define RESUME_BUSY_NS 200

`endif

// *** flash_erase_pkg.sv ***
// Purpose: types shared by the erase command logic
// Assumes: nothing
// Notes: state encodings left to the tools
package flash_erase_pkg;

  typedef enum logic [1:0] {KIND_SECTOR, KIND_BLK32, KIND_BLK64, KIND_CHIP} erase_kind_t;
  typedef enum logic {E_IDLE, E_RUN} erase_state_t;
  typedef enum logic [1:0] {S_NONE, S_WAIT, S_HELD} susp_state_t;
  typedef enum logic {SK_ERASE, SK_PROGRAM} susp_kind_t;

endpackage : flash_erase_pkg

// *** frame_if.sv ***
// Purpose: byte and frame events from the link receiver
// Assumes: all signals on the core clock
// Notes: pulses last one cycle
`timescale 1ns/1ns
interface frame_if;
  logic byte_valid;
  logic [7:0] byte_data;
  logic frame_start;
  logic frame_end;
  logic aligned;

  modport rx (output byte_valid, output byte_data, output frame_start, output frame_end, output aligned);
  modport cmd (input byte_valid, input byte_data, input frame_start, input frame_end, input aligned);
endinterface : frame_if

// *** spi_frame_rx.sv ***
// Purpose: oversample the serial link and cut it into bytes
// Assumes: link clock at most a quarter of the core clock
// Notes: mode 0 sampling on the link clock rising edge
`timescale 1ns/1ns
module spi_frame_rx (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // link pins
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic mosi_in,
  // events
  frame_if.rx frm
);

  logic [1:0] cs_sync_reg;
  logic [1:0] sclk_sync_reg;
  logic [1:0] mosi_sync_reg;
  logic cs_last_reg;
  logic sclk_last_reg;
  logic [6:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic byte_valid_reg;
  logic [7:0] byte_data_reg;
  logic frame_start_reg;
  logic frame_end_reg;
  logic aligned_reg;
  logic sclk_rise;
  logic cs_low;

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  // data is delayed as much as the clock, so sampling stays aligned
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cs_sync_reg <= 2'h3;
      sclk_sync_reg <= 2'h0;
      mosi_sync_reg <= 2'h0;
      cs_last_reg <= 1'h1;
      sclk_last_reg <= 1'h0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], cs_n_in};
      sclk_sync_reg <= {sclk_sync_reg[0], sclk_in};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi_in};
      cs_last_reg <= cs_sync_reg[1];
      sclk_last_reg <= sclk_sync_reg[1];
    end
  end

  assign sclk_rise = sclk_sync_reg[1] && !sclk_last_reg;
  assign cs_low = !cs_sync_reg[1];

  // ----------------------------------------
  // shifter
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shift_reg <= 7'h00;
      bit_cnt_reg <= 3'h0;
      byte_valid_reg <= 1'h0;
      byte_data_reg <= 8'h00;
      frame_start_reg <= 1'h0;
      frame_end_reg <= 1'h0;
      aligned_reg <= 1'h0;
    end else begin
      byte_valid_reg <= cs_low && sclk_rise && (bit_cnt_reg == 3'h7);
      frame_start_reg <= cs_last_reg && cs_low;
      frame_end_reg <= !cs_last_reg && !cs_low;
      if (!cs_last_reg && !cs_low) begin
        aligned_reg <= (bit_cnt_reg == 3'h0);
      end
      if (cs_last_reg && cs_low) begin
        bit_cnt_reg <= 3'h0;
      end else if (cs_low && sclk_rise) begin
        shift_reg <= {shift_reg[5:0], mosi_sync_reg[1]};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
          byte_data_reg <= {shift_reg, mosi_sync_reg[1]};
        end
      end
    end
  end

  assign frm.byte_valid = byte_valid_reg;
  assign frm.byte_data = byte_data_reg;
  assign frm.frame_start = frame_start_reg;
  assign frm.frame_end = frame_end_reg;
  assign frm.aligned = aligned_reg;

endmodule : spi_frame_rx

// *** erase_suspend_ctrl.sv ***
// Purpose: erase, suspend and resume command handling of a serial flash
// Assumes: protection lookup and program engine are same-clock logic
// Notes: the array itself applies the erase on erase_done_out
//
// Function
// - 20h plus 24-bit address erases the 4 KB sector holding it to ones.
// - 52h plus 24-bit address erases the 32 KB block holding it to ones.
// - D8h plus 24-bit address erases the 64 KB block holding it to ones.
// - C7h or 60h alone erases the whole array to ones.
// - Erase accepted only while the write enable latch is set.
// - Chip select must rise right after a whole last byte, else discarded.
// - Erase runs self-timed from chip select rise for its kind's duration.
// - Busy reads one through the erase, zero when it completes.
// - Write enable latch cleared when an erase or program finishes.
// - Sector or block erase skipped when its target is protected.
// - Chip erase skipped when any region is protected.
// - Suspend taken only with suspend clear, busy set, erase or program running.
// - Suspend ignored during chip erase.
// - Erase suspended: write status and all erase commands refused.
// - Program suspended: write status and program commands refused.
// - Suspend sets suspend bit at once, busy falls within the latency.
// - Resume taken only with suspend set and busy clear.
// - Resume clears suspend at once, busy set within 200 ns, work finishes.
// - Power loss while suspended resets and clears the suspend bit.
// - Resume ignored after a suspend lost to power failure.
`timescale 1ns/1ns
`include "flash_erase_params.svh"
module erase_suspend_ctrl #(
  parameter int unsigned SECTOR_ERASE_CYC = `SECTOR_ERASE_US * `CLK_MHZ,
  parameter int unsigned BLK32_ERASE_CYC = `BLK32_ERASE_US * `CLK_MHZ,
  parameter int unsigned BLK64_ERASE_CYC = `BLK64_ERASE_US * `CLK_MHZ,
  parameter int unsigned CHIP_ERASE_CYC = `CHIP_ERASE_US * `CLK_MHZ,
  parameter int SUSP_CYC = `SUSPEND_LAT_US * `CLK_MHZ
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // link pins
  input wire logic spi_cs_n_in,
  input wire logic spi_sclk_in,
  input wire logic spi_mosi_in,
  // shared status and neighbours
  input wire logic write_enable_latch_in,
  input wire logic program_busy_in,
  input wire logic [23:0] program_addr_in,
  input wire logic target_protected_in,
  input wire logic any_protected_in,
  // protection lookup
  output logic [23:0] query_addr_out,
  // status
  output logic busy_out,
  output logic suspend_status_bit_out,
  output logic wel_clear_out,
  // array
  output logic erase_done_out,
  output logic [23:0] erase_addr_out,
  output flash_erase_pkg::erase_kind_t erase_kind_out,
  // gates for other command blocks
  output logic program_hold_out,
  output logic write_status_block_out,
  output logic program_block_out,
  output logic erase_block_out
);

  localparam int RESUME_CYC = `RESUME_BUSY_NS * `CLK_MHZ / 1000;
  localparam int SUSP_BOUND = SUSP_CYC + 2;

  frame_if frm ();

  logic [7:0] opcode_reg;
  logic [2:0] nbytes_reg;
  logic [23:0] addr_reg;
  flash_erase_pkg::erase_state_t e_state_reg;
  flash_erase_pkg::erase_kind_t e_kind_reg;
  logic [31:0] remain_reg;
  flash_erase_pkg::susp_state_t s_state_reg;
  flash_erase_pkg::susp_kind_t s_kind_reg;
  logic [31:0] s_cnt_reg;
  logic busy_reg;
  logic busy_next;
  logic prog_busy_last_reg;
  logic done_reg;
  logic wel_clear_reg;
  logic [23:0] done_addr_reg;
  logic cmd_end;
  logic is_addr_erase;
  logic is_chip_erase;
  logic suspend_status_bit;
  logic erase_held;
  logic prog_held;
  logic sector_clash;
  logic erase_go;
  logic susp_go;
  logic resume_go;
  logic erase_last;
  flash_erase_pkg::erase_kind_t cmd_kind;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic flash_erase_pkg::erase_kind_t kind_of(input logic [7:0] op);
    if (op == `OP_SECTOR_ERASE) begin
      kind_of = flash_erase_pkg::KIND_SECTOR;
    end else if (op == `OP_BLK32_ERASE) begin
      kind_of = flash_erase_pkg::KIND_BLK32;
    end else if (op == `OP_BLK64_ERASE) begin
      kind_of = flash_erase_pkg::KIND_BLK64;
    end else begin
      kind_of = flash_erase_pkg::KIND_CHIP;
    end
  endfunction : kind_of

  // first byte of the region the erase covers
  function automatic logic [23:0] base_of(input flash_erase_pkg::erase_kind_t kind,
                                          input logic [23:0] addr);
    case (kind)
      flash_erase_pkg::KIND_SECTOR: base_of = {addr[23:`SECTOR_ADDR_LSB], 12'h000};
      flash_erase_pkg::KIND_BLK32: base_of = {addr[23:`BLK32_ADDR_LSB], 15'h0000};
      flash_erase_pkg::KIND_BLK64: base_of = {addr[23:`BLK64_ADDR_LSB], 16'h0000};
      default: base_of = 24'h000000;
    endcase
  endfunction : base_of

  function automatic logic [31:0] duration_of(input flash_erase_pkg::erase_kind_t kind);
    case (kind)
      flash_erase_pkg::KIND_SECTOR: duration_of = SECTOR_ERASE_CYC;
      flash_erase_pkg::KIND_BLK32: duration_of = BLK32_ERASE_CYC;
      flash_erase_pkg::KIND_BLK64: duration_of = BLK64_ERASE_CYC;
      default: duration_of = CHIP_ERASE_CYC;
    endcase
  endfunction : duration_of

  // ----------------------------------------
  // link receiver
  // ----------------------------------------
  spi_frame_rx u_rx (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .cs_n_in(spi_cs_n_in),
    .sclk_in(spi_sclk_in),
    .mosi_in(spi_mosi_in),
    .frm(frm.rx)
  );

  // ----------------------------------------
  // command capture
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      opcode_reg <= 8'h00;
      nbytes_reg <= 3'h0;
      addr_reg <= 24'h000000;
    end else if (frm.frame_start) begin
      nbytes_reg <= 3'h0;
    end else if (frm.byte_valid) begin
      if (nbytes_reg == 3'h0) begin
        opcode_reg <= frm.byte_data;
      end else if (nbytes_reg < `LEN_ADDR_CMD) begin
        addr_reg <= {addr_reg[15:0], frm.byte_data};
      end
      // saturate so an overlong frame never aliases a short one
      if (nbytes_reg != 3'h7) begin
        nbytes_reg <= nbytes_reg + 3'h1;
      end
    end
  end

  assign query_addr_out = addr_reg;

  // ----------------------------------------
  // decode and gating
  // ----------------------------------------
  assign cmd_end = frm.frame_end && frm.aligned;
  assign is_addr_erase = (nbytes_reg == `LEN_ADDR_CMD) && ((opcode_reg == `OP_SECTOR_ERASE) ||
                         (opcode_reg == `OP_BLK32_ERASE) || (opcode_reg == `OP_BLK64_ERASE));
  assign is_chip_erase = (nbytes_reg == `LEN_BARE_CMD) &&
                         ((opcode_reg == `OP_CHIP_ERASE_A) || (opcode_reg == `OP_CHIP_ERASE_B));
  assign cmd_kind = kind_of(opcode_reg);

  assign suspend_status_bit = (s_state_reg != flash_erase_pkg::S_NONE);
  assign erase_held = suspend_status_bit && (s_kind_reg == flash_erase_pkg::SK_ERASE);
  assign prog_held = suspend_status_bit && (s_kind_reg == flash_erase_pkg::SK_PROGRAM);
  // while a program is held, refuse chip erase and any erase addressed inside the held page's 4 KB sector
  assign sector_clash = prog_held && (is_chip_erase ||
    (base_of(flash_erase_pkg::KIND_SECTOR, addr_reg) ==
     base_of(flash_erase_pkg::KIND_SECTOR, program_addr_in)));

  assign erase_go = cmd_end && write_enable_latch_in && !busy_reg
                    && !erase_held && !sector_clash
                    && ((is_addr_erase && !target_protected_in)
                        || (is_chip_erase && !any_protected_in));

  assign susp_go = cmd_end && (opcode_reg == `OP_SUSPEND) && (nbytes_reg == `LEN_BARE_CMD)
                   && !suspend_status_bit && busy_reg
                   && (((e_state_reg == flash_erase_pkg::E_RUN) &&
                        (e_kind_reg != flash_erase_pkg::KIND_CHIP))
                       || program_busy_in);

  // after power loss the suspend bit is already clear, so resume finds nothing
  assign resume_go = cmd_end && (opcode_reg == `OP_RESUME) && (nbytes_reg == `LEN_BARE_CMD)
                     && (s_state_reg == flash_erase_pkg::S_HELD) && !busy_reg;

  // ----------------------------------------
  // erase timer
  // ----------------------------------------
  assign erase_last = (e_state_reg == flash_erase_pkg::E_RUN) && !erase_held &&
                      (remain_reg == 32'h00000001);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      e_state_reg <= flash_erase_pkg::E_IDLE;
      e_kind_reg <= flash_erase_pkg::KIND_SECTOR;
      remain_reg <= 32'h00000000;
      done_addr_reg <= 24'h000000;
    end else begin
      case (e_state_reg)
        flash_erase_pkg::E_IDLE: begin
          if (erase_go) begin
            e_state_reg <= flash_erase_pkg::E_RUN;
            e_kind_reg <= cmd_kind;
            remain_reg <= duration_of(cmd_kind);
            done_addr_reg <= base_of(cmd_kind, addr_reg);
          end
        end
        flash_erase_pkg::E_RUN: begin
          // frozen while suspended so the remaining time is kept
          if (erase_last) begin
            e_state_reg <= flash_erase_pkg::E_IDLE;
          end else if (!erase_held) begin
            remain_reg <= remain_reg - 32'h00000001;
          end
        end
        default: e_state_reg <= flash_erase_pkg::E_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // suspend and resume
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_state_reg <= flash_erase_pkg::S_NONE;
      s_kind_reg <= flash_erase_pkg::SK_ERASE;
      s_cnt_reg <= 32'h00000000;
    end else begin
      case (s_state_reg)
        flash_erase_pkg::S_NONE: begin
          if (susp_go) begin
            s_state_reg <= flash_erase_pkg::S_WAIT;
            s_cnt_reg <= 32'(SUSP_CYC);
            s_kind_reg <= (e_state_reg == flash_erase_pkg::E_RUN) ?
                          flash_erase_pkg::SK_ERASE : flash_erase_pkg::SK_PROGRAM;
          end
        end
        flash_erase_pkg::S_WAIT: begin
          if (s_cnt_reg <= 32'h00000001) begin
            s_state_reg <= flash_erase_pkg::S_HELD;
          end else begin
            s_cnt_reg <= s_cnt_reg - 32'h00000001;
          end
        end
        flash_erase_pkg::S_HELD: begin
          if (resume_go) begin
            s_state_reg <= flash_erase_pkg::S_NONE;
          end
        end
        default: s_state_reg <= flash_erase_pkg::S_NONE;
      endcase
    end
  end

  // ----------------------------------------
  // status bits
  // ----------------------------------------
  // busy also covers the suspend latency so the host sees it fall late
  assign busy_next = erase_go ||
                     ((e_state_reg == flash_erase_pkg::E_RUN) && !erase_held) ||
                     (s_state_reg == flash_erase_pkg::S_WAIT) ||
                     (program_busy_in && !prog_held);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_reg <= 1'h0;
    end else begin
      busy_reg <= busy_next;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prog_busy_last_reg <= 1'h0;
      done_reg <= 1'h0;
      wel_clear_reg <= 1'h0;
    end else begin
      prog_busy_last_reg <= program_busy_in;
      done_reg <= erase_last;
      wel_clear_reg <= erase_last || (prog_busy_last_reg && !program_busy_in);
    end
  end

  assign busy_out = busy_reg;
  assign suspend_status_bit_out = suspend_status_bit;
  assign wel_clear_out = wel_clear_reg;
  assign erase_done_out = done_reg;
  assign erase_addr_out = done_addr_reg;
  assign erase_kind_out = e_kind_reg;
  assign program_hold_out = prog_held;
  assign write_status_block_out = suspend_status_bit;
  assign program_block_out = prog_held;
  assign erase_block_out = erase_held;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  wel_gate_a: assert property (erase_go |-> write_enable_latch_in && !busy_out)
    else $error("erase started without write enable or while busy");
  frame_align_a: assert property (erase_go |-> frm.aligned && frm.frame_end)
    else $error("erase started off a whole-byte frame end");
  erase_busy_a: assert property (erase_go |=> ##1 busy_out [*2])
    else $error("busy not set after erase start");
  done_wel_a: assert property ($rose(erase_done_out) |-> wel_clear_out && !$past(erase_held))
    else $error("erase done without write enable clear");
  protect_skip_a: assert property (erase_go && is_addr_erase |-> !target_protected_in)
    else $error("protected region erased");
  chip_protect_a: assert property (erase_go && is_chip_erase |-> !any_protected_in)
    else $error("chip erase with protection set");
  chip_nosusp_a: assert property ((e_state_reg == flash_erase_pkg::E_RUN) &&
    (e_kind_reg == flash_erase_pkg::KIND_CHIP) && !prog_held |=> !suspend_status_bit_out)
    else $error("chip erase was suspended");
  susp_take_a: assert property (susp_go |=> suspend_status_bit_out ##[1:SUSP_BOUND] !busy_out)
    else $error("suspend bit late or busy not dropped");
  susp_refuse_a: assert property (suspend_status_bit_out && busy_out |=> !$fell(suspend_status_bit_out))
    else $error("resume taken while busy");
  resume_busy_a: assert property (resume_go |=> !suspend_status_bit_out ##[0:RESUME_CYC] busy_out)
    else $error("resume did not restore busy in time");
  held_freeze_a: assert property (erase_held && (e_state_reg == flash_erase_pkg::E_RUN) |=>
    $stable(remain_reg))
    else $error("erase advanced while suspended");

endmodule : erase_suspend_ctrl

// *** spi_host_model.sv ***
// Purpose: host side of the serial link for the erase block
// Assumes: mode 0, link clock period 64 ns
// Notes: clock parked low outside frames
`timescale 1ns/1ns
module spi_host_model (
  // link pins
  output logic cs_n_out,
  output logic sclk_out,
  output logic mosi_out
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end

  // ----------------------------------------
  // one frame, msb first
  // ----------------------------------------
  // odd bit counts make a torn last byte on purpose
  task automatic send(input logic [39:0] bits, input int nbits);
    cs_n_out = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      mosi_out = bits[i];
      #32 sclk_out = 1'b1;
      #32 sclk_out = 1'b0;
    end
    #32 cs_n_out = 1'b1;
    // released line must not keep the last bit
    mosi_out = ~mosi_out;
  endtask : send
endmodule : spi_host_model

// *** tb_erase_suspend_ctrl.sv ***
// Purpose: self-checking bench of the erase / suspend / resume logic
// Assumes: shortened erase and suspend counts
// Notes: expected values from an integer model of the rules
`timescale 1ns/1ns
module tb_erase_suspend_ctrl;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic write_enable_latch, pbusy, prot, anyp, busy, susp, welc, done, hold, blk_ws, blk_pg, blk_er;
  logic [23:0] paddr, a;
  logic [23:0] qaddr, eaddr;
  flash_erase_pkg::erase_kind_t ekind;
  wire cs_n, sclk, mosi;
  int failures = 0;
  int n_tests = 0;
  int seed = 32'h3078;
  logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
  int sz [3] = '{4096, 32768, 65536};
  int cyc [4] = '{400, 500, 600, 700};

  always #4 clk_in = ~clk_in;

  spi_host_model host (.cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi));

  erase_suspend_ctrl #(.SECTOR_ERASE_CYC(400), .BLK32_ERASE_CYC(500), .BLK64_ERASE_CYC(600),
    .CHIP_ERASE_CYC(700), .SUSP_CYC(10)) uut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .spi_cs_n_in(cs_n), .spi_sclk_in(sclk),
    .spi_mosi_in(mosi), .write_enable_latch_in(write_enable_latch), .program_busy_in(pbusy),
    .program_addr_in(paddr), .target_protected_in(prot), .any_protected_in(anyp),
    .query_addr_out(qaddr), .busy_out(busy), .suspend_status_bit_out(susp),
    .wel_clear_out(welc), .erase_done_out(done), .erase_addr_out(eaddr),
    .erase_kind_out(ekind), .program_hold_out(hold), .write_status_block_out(blk_ws),
    .program_block_out(blk_pg), .erase_block_out(blk_er));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic print_verdict;
    $display("counts: %0d compares, %0d mismatches", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step

  // gap first keeps the minimum spacing between frames
  task automatic frame(input logic [39:0] b, input int nb);
    step(64);
    host.send(b, nb);
    step(10);
  endtask : frame

  task automatic wait_done(input int lo, input int hi);
    int n;
    n = 0;
    while (done !== 1'b1) begin
      step(1);
      n++;
      if (n > hi) begin
        check(n, hi);
        print_verdict();
      end
    end
    check(n >= lo, 1'b1);
  endtask : wait_done

  task automatic run_erase(input int i, input logic w, input logic tp, input logic ap, input logic go);
    int k;
    k = (i > 3) ? 3 : i;
    a = 24'($random(seed));
    write_enable_latch = w;
    prot = tp;
    anyp = ap;
    if (k == 3) frame(ops[i], 8);
    else frame({ops[i], a}, 32);
    check(busy, go);
    // protection lookup must see the address just shifted in
    if (k != 3) check(qaddr, a);
    if (go) begin
      wait_done(cyc[k] - 10, cyc[k] + 4);
      check(eaddr, (k == 3) ? 0 : (a & ~(sz[k] - 1)));
      check(ekind, k);
      check(welc, 1'b1);
      step(4);
      check(busy, 1'b0);
    end
    write_enable_latch = 1'b0;
    prot = 1'b0;
    anyp = 1'b0;
  endtask : run_erase

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    write_enable_latch = 1'b0;
    pbusy = 1'b0;
    prot = 1'b0;
    anyp = 1'b0;
    paddr = 24'h000000;
    step(12);
    arst_n_in = 1'b1;
    step(3);
    for (int i = 0; i < 5; i++) run_erase(i, 1'b1, 1'b0, 1'b0, 1'b1);
    $display("test erase kinds done");
    run_erase(0, 1'b0, 1'b0, 1'b0, 1'b0);
    run_erase(2, 1'b1, 1'b1, 1'b1, 1'b0);
    run_erase(4, 1'b1, 1'b0, 1'b1, 1'b0);
    write_enable_latch = 1'b1;
    frame({8'h20, 24'h000000, 1'b1}, 33);
    check(busy, 1'b0);
    frame(8'h7A, 8);
    frame(8'h75, 8);
    check(susp, 1'b0);
    $display("test refusals done");
    frame({8'h20, 24'h003000}, 32);
    frame(8'h75, 8);
    check(susp, 1'b1);
    check(blk_er, 1'b1);
    check(blk_ws, 1'b1);
    step(14);
    check(busy, 1'b0);
    frame({8'h52, 24'h010000}, 32);
    frame(8'h75, 8);
    check({busy, susp}, 2'b01);
    frame(8'h7A, 8);
    check({busy, susp}, 2'b10);
    wait_done(1, 400);
    check(eaddr, 24'h003000);
    $display("test erase suspend done");
    frame(8'hC7, 8);
    frame(8'h75, 8);
    check({busy, susp}, 2'b10);
    wait_done(1, 700);
    frame({8'h20, 24'h005000}, 32);
    frame(8'h75, 8);
    step(14);
    arst_n_in = 1'b0;
    step(3);
    arst_n_in = 1'b1;
    step(3);
    check({busy, susp}, 2'b00);
    frame(8'h7A, 8);
    check({busy, susp}, 2'b00);
    $display("test power loss done");
    paddr = 24'($random(seed));
    pbusy = 1'b1;
    frame(8'h75, 8);
    check({hold, blk_pg, blk_ws, blk_er}, 4'hE);
    // erases addressed in the suspended page's sector, and chip erase, are refused
    frame({8'h20, paddr}, 32);
    check(busy, 1'b0);
    frame(8'hC7, 8);
    check(busy, 1'b0);
    frame({8'h20, paddr ^ 24'h001000}, 32);
    check(busy, 1'b1);
    wait_done(1, 400);
    check(eaddr, (paddr ^ 24'h001000) & 24'hFFF000);
    write_enable_latch = 1'b0;
    // resume clears hold and suspend at once, busy back with the program
    frame(8'h7A, 8);
    check({hold, susp, busy}, 3'b001);
    pbusy = 1'b0;
    step(1);
    check(welc, 1'b1);
    $display("test program suspend done");
    print_verdict();
  end
endmodule : tb_erase_suspend_ctrl
